// >>> core/uart_line_format_control.sv
// serial transceiver whose character format follows the line format register
module uart_line_format_control
    import uart_format_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_rxd,
    output logic o_txd
);

    // register file
    line_format_s format_reg;
    logic [15:0] div_reg;
    logic [7:0] feature_reg;
    logic [7:0] scratch_reg;
    logic [7:0] rdata_reg;
    logic txd_reg;

    // transmitter
    frame_state_e tx_state_reg;
    frame_state_e tx_state_next;
    logic [18:0] tx_cnt_reg;
    logic [2:0] tx_half_reg;
    logic [2:0] tx_bitn_reg;
    logic [7:0] tx_shift_reg;
    logic tx_par_reg;
    logic tx_line_reg;
    logic tx_line_next;

    // receiver
    frame_state_e rx_state_reg;
    logic [18:0] rx_cnt_reg;
    logic rx_half_reg;
    logic [2:0] rx_bitn_reg;
    logic [7:0] rx_shift_reg;
    logic rx_par_reg;
    logic [7:0] rx_data_reg;
    logic rx_ready_reg;
    logic rx_perr_reg;
    logic rx_ferr_reg;

    wire logic bank = format_reg.bank_select_bit;
    wire logic [18:0] half_period = (div_reg == 16'h0000) ? 19'(1 << HALF_BIT_SHIFT)
                                                          : {div_reg, 3'b000};
    wire logic [2:0] last_bit = {1'b0, format_reg.char_length_field} + 3'(CHAR_BASE - 1);
    // stop length bit set: 1.5 stop bits only for 5-bit words, otherwise 2; bit clear: 1 stop bit
    wire logic [2:0] stop_halves = !format_reg.stop_length_bit ? 3'd2 :
                                   (format_reg.char_length_field == 2'b00) ? 3'd3 : 3'd4;

    // host decode; the format register is reachable in either bank
    wire logic hit_format = i_addr == ADDR_FORMAT;
    wire logic wr_format = i_wr && hit_format;
    wire logic wr_div_lo = i_wr && bank && i_addr == ADDR_DIV_LO;
    wire logic wr_div_hi = i_wr && bank && i_addr == ADDR_DIV_HI;
    wire logic wr_feature = i_wr && bank && i_addr == ADDR_FEATURE;
    wire logic wr_scratch = i_wr && !bank && i_addr == ADDR_SCRATCH;
    wire logic wr_tx = i_wr && !bank && i_addr == ADDR_DATA;
    wire logic rd_rx = i_rd && !bank && i_addr == ADDR_DATA;
    wire logic rd_status = i_rd && !bank && i_addr == ADDR_STATUS;
    // a write while a character is in flight is dropped; poll the idle flag first
    wire logic tx_load = wr_tx && tx_state_reg == S_IDLE;

    wire logic [7:0] status_word = 8'((rx_ready_reg << ST_RX_READY)
                                    | (rx_perr_reg << ST_PARITY_ERR)
                                    | (rx_ferr_reg << ST_FRAME_ERR)
                                    | ((tx_state_reg == S_IDLE) << ST_TX_IDLE));

    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (hit_format) begin
            rd_mux = format_reg;
        end else if (bank) begin
            case (i_addr)
                ADDR_DIV_LO: rd_mux = div_reg[7:0];
                ADDR_DIV_HI: rd_mux = div_reg[15:8];
                ADDR_FEATURE: rd_mux = feature_reg;
                default: rd_mux = 8'h00;
            endcase
        end else begin
            case (i_addr)
                ADDR_DATA: rd_mux = rx_data_reg;
                ADDR_STATUS: rd_mux = status_word;
                ADDR_SCRATCH: rd_mux = scratch_reg;
                default: rd_mux = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            format_reg <= FORMAT_RST;
            div_reg <= DIV_RST;
            feature_reg <= FEATURE_RST;
            scratch_reg <= SCRATCH_RST;
            rdata_reg <= 8'h00;
        end else begin
            if (wr_format) format_reg <= i_wdata;
            if (wr_div_lo) div_reg[7:0] <= i_wdata;
            if (wr_div_hi) div_reg[15:8] <= i_wdata;
            if (wr_feature) feature_reg <= i_wdata;
            if (wr_scratch) scratch_reg <= i_wdata;
            rdata_reg <= i_rd ? rd_mux : 8'h00;
        end
    end

    // transmit half-bit timebase restarts with each character
    wire logic tx_tick = tx_state_reg != S_IDLE && tx_cnt_reg == half_period - 19'd1;
    // stop counts its own halves; a bit end there would restart the count and hang
    wire logic tx_bit_end = tx_tick && tx_half_reg == 3'd1 && tx_state_reg != S_STOP;
    wire logic tx_stop_end = tx_tick && tx_half_reg == stop_halves - 3'd1;

    always_comb begin
        tx_state_next = tx_state_reg;
        tx_line_next = tx_line_reg;
        case (tx_state_reg)
            S_IDLE: begin
                if (tx_load) begin
                    tx_state_next = S_START;
                    tx_line_next = 1'b0;
                end
            end
            S_START: begin
                if (tx_bit_end) begin
                    tx_state_next = S_DATA;
                    tx_line_next = tx_shift_reg[0];
                end
            end
            S_DATA: begin
                if (tx_bit_end && tx_bitn_reg == last_bit) begin
                    if (format_reg.parity_on_bit) begin
                        tx_state_next = S_PARITY;
                        tx_line_next = tx_par_reg;
                    end else begin
                        tx_state_next = S_STOP;
                        tx_line_next = 1'b1;
                    end
                end else if (tx_bit_end) begin
                    tx_line_next = tx_shift_reg[1];
                end
            end
            S_PARITY: begin
                if (tx_bit_end) begin
                    tx_state_next = S_STOP;
                    tx_line_next = 1'b1;
                end
            end
            S_STOP: begin
                if (tx_stop_end) begin
                    tx_state_next = S_IDLE;
                end
            end
            default: begin
                tx_state_next = S_IDLE;
                tx_line_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tx_state_reg <= S_IDLE;
            tx_cnt_reg <= 19'h00000;
            tx_half_reg <= 3'h0;
            tx_bitn_reg <= 3'h0;
            tx_shift_reg <= 8'h00;
            tx_par_reg <= 1'b0;
            tx_line_reg <= 1'b1;
            txd_reg <= 1'b1;
        end else begin
            tx_state_reg <= tx_state_next;
            tx_line_reg <= tx_line_next;
            // break overrides any frame; the character keeps timing underneath
            txd_reg <= tx_line_next & ~format_reg.break_force_bit;
            if (tx_load) begin
                tx_shift_reg <= i_wdata;
                tx_par_reg <= parity_calc(i_wdata, format_reg);
                tx_bitn_reg <= 3'h0;
            end else if (tx_bit_end && tx_state_reg == S_DATA) begin
                tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                tx_bitn_reg <= tx_bitn_reg + 3'd1;
            end
            if (tx_load || tx_tick) begin
                tx_cnt_reg <= 19'h00000;
            end else if (tx_state_reg != S_IDLE) begin
                tx_cnt_reg <= tx_cnt_reg + 19'd1;
            end
            if (tx_load || tx_bit_end || tx_stop_end) begin
                tx_half_reg <= 3'h0;
            end else if (tx_tick) begin
                tx_half_reg <= tx_half_reg + 3'd1;
            end
        end
    end

    // receive timebase restarts on the start edge so samples land mid-bit
    wire logic rx_tick = rx_state_reg != S_IDLE && rx_cnt_reg == half_period - 19'd1;
    wire logic rx_sample = rx_tick && (rx_state_reg == S_START || rx_half_reg);
    wire logic [7:0] rx_word = rx_shift_reg;
    // only the first stop bit is checked
    wire logic rx_done = rx_sample && rx_state_reg == S_STOP;
    wire logic rx_perr_set = rx_done && format_reg.parity_on_bit
                             && rx_par_reg != parity_calc(rx_word, format_reg);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_state_reg <= S_IDLE;
            rx_cnt_reg <= 19'h00000;
            rx_half_reg <= 1'b0;
            rx_bitn_reg <= 3'h0;
            rx_shift_reg <= 8'h00;
            rx_par_reg <= 1'b0;
        end else begin
            if (rx_state_reg == S_IDLE || rx_tick) begin
                rx_cnt_reg <= 19'h00000;
            end else begin
                rx_cnt_reg <= rx_cnt_reg + 19'd1;
            end
            if (rx_sample || rx_state_reg == S_IDLE) begin
                rx_half_reg <= 1'b0;
            end else if (rx_tick) begin
                rx_half_reg <= 1'b1;
            end
            case (rx_state_reg)
                S_IDLE: begin
                    if (!i_rxd) begin
                        rx_state_reg <= S_START;
                        rx_shift_reg <= 8'h00;
                        rx_bitn_reg <= 3'h0;
                    end
                end
                S_START: begin
                    // a glitch shorter than half a bit is not a start
                    if (rx_sample) rx_state_reg <= i_rxd ? S_IDLE : S_DATA;
                end
                S_DATA: begin
                    if (rx_sample) begin
                        rx_shift_reg[rx_bitn_reg] <= i_rxd;
                        rx_bitn_reg <= rx_bitn_reg + 3'd1;
                        if (rx_bitn_reg == last_bit) begin
                            rx_state_reg <= format_reg.parity_on_bit ? S_PARITY : S_STOP;
                        end
                    end
                end
                S_PARITY: begin
                    if (rx_sample) begin
                        rx_par_reg <= i_rxd;
                        rx_state_reg <= S_STOP;
                    end
                end
                S_STOP: begin
                    if (rx_sample) rx_state_reg <= S_IDLE;
                end
                default: rx_state_reg <= S_IDLE;
            endcase
        end
    end

    // receive status: a new character wins over a read in the same cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_data_reg <= 8'h00;
            rx_ready_reg <= 1'b0;
            rx_perr_reg <= 1'b0;
            rx_ferr_reg <= 1'b0;
        end else begin
            if (rx_done) begin
                rx_data_reg <= rx_word;
                rx_ready_reg <= 1'b1;
            end else if (rd_rx) begin
                rx_ready_reg <= 1'b0;
            end
            if (rx_perr_set) begin
                rx_perr_reg <= 1'b1;
            end else if (rd_status) begin
                rx_perr_reg <= 1'b0;
            end
            if (rx_done && !i_rxd) begin
                rx_ferr_reg <= 1'b1;
            end else if (rd_status) begin
                rx_ferr_reg <= 1'b0;
            end
        end
    end

    assign o_rdata = rdata_reg;
    assign o_txd = txd_reg;

endmodule : uart_line_format_control

// >>> core/uart_format_pkg.sv
// package: register map, line format layout and frame states of the serial line block
package uart_format_pkg;

    // register offsets on the 3-bit host port
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_DIV_LO = 3'h0;
    localparam logic [2:0] ADDR_DIV_HI = 3'h1;
    localparam logic [2:0] ADDR_FEATURE = 3'h2;
    localparam logic [2:0] ADDR_FORMAT = 3'h3;
    localparam logic [2:0] ADDR_STATUS = 3'h5;
    localparam logic [2:0] ADDR_SCRATCH = 3'h7;

    // reset values
    localparam logic [7:0] FORMAT_RST = 8'h00;
    localparam logic [15:0] DIV_RST = 16'h0001;
    localparam logic [7:0] FEATURE_RST = 8'h00;
    localparam logic [7:0] SCRATCH_RST = 8'h00;

    // status register bit positions
    localparam int ST_RX_READY = 0;
    localparam int ST_PARITY_ERR = 2;
    localparam int ST_FRAME_ERR = 3;
    localparam int ST_TX_IDLE = 5;

    // one bit time is divisor * 16 clocks; the logic steps in half bits
    localparam int HALF_BIT_SHIFT = 3;
    localparam int CHAR_BASE = 5;

    typedef struct packed {
        logic bank_select_bit;
        logic break_force_bit;
        logic fixed_parity_bit;
        logic parity_sense_bit;
        logic parity_on_bit;
        logic stop_length_bit;
        logic [1:0] char_length_field;
    } line_format_s;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_START = 3'b001,
        S_DATA = 3'b010,
        S_PARITY = 3'b011,
        S_STOP = 3'b100
    } frame_state_e;

    // parity over the selected data bits only; forced modes ignore the data
    function automatic logic parity_calc(input logic [7:0] data, input line_format_s fmt);
        logic [7:0] mask;
        logic ones;
        mask = 8'hFF >> (3'd3 - {1'b0, fmt.char_length_field});
        ones = ^(data & mask);
        if (fmt.fixed_parity_bit) begin
            parity_calc = ~fmt.parity_sense_bit;
        end else begin
            parity_calc = fmt.parity_sense_bit ? ones : ~ones;
        end
    endfunction : parity_calc

endpackage : uart_format_pkg

// >>> tb/uart_format_assertions.sv
// checker: port-level properties of the line format block
module uart_format_assertions (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic i_rxd,
    input wire logic o_txd
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] fmt_reg;
    logic [7:0] div_hi_reg;
    logic [7:0] hi_cnt_reg;
    logic [7:0] hi_cnt_next;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // counts high line time; 200 exceeds any high run inside a frame
    assign hi_cnt_next = !o_txd ? 8'h00 : hi_cnt_reg + {7'h00, hi_cnt_reg != 8'hFF};
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            fmt_reg <= 8'h00;
            div_hi_reg <= 8'h00;
            hi_cnt_reg <= 8'h00;
        end else begin
            if (i_wr && i_addr == 3'h3) fmt_reg <= i_wdata;
            if (i_wr && i_addr == 3'h1 && fmt_reg[7]) div_hi_reg <= i_wdata;
            hi_cnt_reg <= hi_cnt_next;
        end
    end
    // zero data write on an idle line; timing assumes divisor 1
    sequence idle_wr(logic [7:0] f);
        i_wr && i_addr == 3'h0 && i_wdata == 8'h00 && fmt_reg == f && hi_cnt_reg >= 8'd200;
    endsequence
    a_rdata_quiet: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data outside read slot");
    a_format_readback: assert property (i_rd && i_addr == 3'h3 |=> o_rdata == $past(fmt_reg))
        else $error("format register readback wrong");
    a_bank_blocked: assert property (i_rd && fmt_reg[7] && (i_addr == 3'h5 || i_addr == 3'h7)
        |=> o_rdata == 8'h00)
        else $error("general register visible in bank 1");
    a_general_hidden: assert property (i_rd && !fmt_reg[7] && (i_addr == 3'h1 || i_addr == 3'h2)
        |=> o_rdata == 8'h00)
        else $error("divisor or feature visible in bank 0");
    a_divisor_high: assert property (i_rd && fmt_reg[7] && i_addr == 3'h1
        |=> o_rdata == $past(div_hi_reg))
        else $error("divisor high readback wrong");
    a_break_holds: assert property (fmt_reg[6] && $past(fmt_reg[6]) |-> !o_txd)
        else $error("line not low during break");
    a_five_bit_frame: assert property (idle_wr(8'h00) |-> ##3 !o_txd ##90 !o_txd ##10 o_txd)
        else $error("five bit frame shape wrong");
    a_odd_parity_bit: assert property (idle_wr(8'h0B) |-> ##140 !o_txd ##14 o_txd ##16 o_txd)
        else $error("odd parity bit wrong");
endmodule : uart_format_assertions

bind uart_line_format_control uart_format_assertions i_chk (.i_clk(i_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_rxd(i_rxd), .o_txd(o_txd));

// >>> tb/remote_serial_model.sv
// remote end of the serial line: frame receiver and sender, 16 clocks a bit
module remote_serial_model
    import uart_format_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_line,
    input wire line_format_s i_fmt,
    output logic o_line,
    output logic [7:0] o_byte,
    output logic o_par_ok,
    output int o_count
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BIT_CLKS = 16;
    function automatic logic exp_par(input logic [7:0] d, input line_format_s f);
        logic ones;
        ones = ^(d & (8'hFF >> (2'd3 - f.char_length_field)));
        if (f.fixed_parity_bit) return !f.parity_sense_bit;
        return f.parity_sense_bit ? ones : !ones;
    endfunction : exp_par
    initial begin
        o_line = 1'b1;
        o_byte = 8'h00;
        o_par_ok = 1'b1;
        o_count = 0;
    end
    // receiver checks the same format the transmitter is set to
    initial begin : rx
        logic [7:0] d;
        int n;
        forever begin
            do @(posedge i_clk); while (i_line !== 1'b0);
            repeat (BIT_CLKS / 2) @(posedge i_clk);
            d = 8'h00;
            n = CHAR_BASE + i_fmt.char_length_field;
            for (int i = 0; i < n; i++) begin
                repeat (BIT_CLKS) @(posedge i_clk);
                d[i] = i_line;
            end
            o_par_ok <= 1'b1;
            if (i_fmt.parity_on_bit) begin
                repeat (BIT_CLKS) @(posedge i_clk);
                o_par_ok <= (i_line === exp_par(d, i_fmt));
            end
            repeat (BIT_CLKS) @(posedge i_clk);
            o_byte <= d;
            o_count <= o_count + 1;
        end
    end
    // flip_par sends a wrong parity bit on request
    task automatic send(input logic [7:0] d, input logic flip_par);
        int n;
        n = CHAR_BASE + i_fmt.char_length_field;
        @(posedge i_clk);
        o_line <= 1'b0;
        for (int i = 0; i < n; i++) begin
            repeat (BIT_CLKS) @(posedge i_clk);
            o_line <= d[i];
        end
        // one drive per edge: parity only when the format carries it
        if (i_fmt.parity_on_bit) begin
            repeat (BIT_CLKS) @(posedge i_clk);
            o_line <= exp_par(d, i_fmt) ^ flip_par;
        end
        repeat (BIT_CLKS) @(posedge i_clk);
        o_line <= 1'b1;
        repeat (2 * BIT_CLKS) @(posedge i_clk);
    endtask : send
endmodule : remote_serial_model

// >>> tb/tb.sv
// self-checking bench of the line format block against a remote serial end
module tb
    import uart_format_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk, i_rst, i_wr, i_rd, i_rxd, o_txd, rem_par_ok;
    logic [2:0] i_addr;
    logic [7:0] i_wdata, o_rdata, rem_byte;
    line_format_s model_fmt;
    int rem_count;
    int fails = 0;
    int num_checks = 0;
    uart_line_format_control i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(i_rxd),
        .o_txd(o_txd));
    remote_serial_model i_remote (.i_clk(i_clk), .i_line(o_txd), .i_fmt(model_fmt),
        .o_line(i_rxd), .o_byte(rem_byte), .o_par_ok(rem_par_ok), .o_count(rem_count));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        v = o_rdata;
    endtask : rd
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(v, exp);
    endtask : rd_chk
    task automatic t_bank;
        rd_chk(3'h3, 8'h00);
        wr(3'h3, 8'h80);
        rd_chk(3'h3, 8'h80);
        rd_chk(3'h0, 8'h01);
        wr(3'h1, 8'h3C);
        rd_chk(3'h1, 8'h3C);
        wr(3'h1, 8'h00);
        wr(3'h2, 8'h77);
        rd_chk(3'h2, 8'h77);
        wr(3'h7, 8'hEE);
        rd_chk(3'h7, 8'h00);
        rd_chk(3'h5, 8'h00);
        wr(3'h3, 8'h00);
        rd_chk(3'h7, 8'h00);
        rd_chk(3'h2, 8'h00);
        wr(3'h7, 8'h5A);
        rd_chk(3'h7, 8'h5A);
        $display("bank select test done");
    endtask : t_bank
    task automatic t_formats;
        logic [7:0] d, v, e, n;
        time t0;
        int k;
        k = rem_count;
        for (int f = 0; f < 64; f++) begin
            for (int j = 0; j < 2; j++) begin
                d = j ? 8'h6D : 8'h00;
                model_fmt = line_format_s'(8'(f));
                wr(3'h3, 8'(f));
                repeat (j ? 0 : 210) @(posedge i_clk);
                wr(3'h0, d);
                t0 = $time;
                v = 8'h00;
                for (int w = 0; w < 150 && !v[ST_TX_IDLE]; w++) rd(3'h5, v);
                n = 8'(($time - t0) / 10);
                e = 8'(2 + 16 * (1 + CHAR_BASE + f % 4 + f[3]) + (!f[2] ? 16 : f % 4 ? 32 : 24));
                chk((n + 8'd2 >= e && n <= e + 8'd3) ? e : n, e);
                k++;
                chk(8'(rem_count), 8'(k));
                chk(rem_byte, d & (8'hFF >> (3 - f % 4)));
                chk({7'h00, rem_par_ok}, 8'h01);
            end
        end
        $display("format table test done");
    endtask : t_formats
    task automatic t_receive;
        logic [7:0] fm[6] = '{8'h1B, 8'h1B, 8'h2B, 8'h3B, 8'h0B, 8'h00};
        logic [7:0] dat[6] = '{8'h96, 8'h96, 8'h3C, 8'h5A, 8'h81, 8'hFF};
        logic flip[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        logic [7:0] v;
        for (int i = 0; i < 6; i++) begin
            wr(3'h3, fm[i]);
            model_fmt = line_format_s'(fm[i]);
            i_remote.send(dat[i], flip[i]);
            rd(3'h5, v);
            chk(v & 8'h0D, {5'h00, flip[i] & fm[i][3], 2'b01});
            rd_chk(3'h0, dat[i] & (8'hFF >> (3 - fm[i][1:0])));
        end
        $display("receive format test done");
    endtask : t_receive
    task automatic t_break;
        wr(3'h3, 8'h43);
        repeat (50) @(posedge i_clk);
        #1;
        chk({7'h00, o_txd}, 8'h00);
        repeat (200) @(posedge i_clk);
        #1;
        chk({7'h00, o_txd}, 8'h00);
        wr(3'h3, 8'h03);
        repeat (3) @(posedge i_clk);
        #1;
        chk({7'h00, o_txd}, 8'h01);
        $display("break test done");
    endtask : t_break
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    initial begin
        i_rst = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 3'h0;
        i_wdata = 8'h00;
        model_fmt = line_format_s'(8'h00);
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        t_bank;
        t_formats;
        t_receive;
        t_break;
        wrap_up;
    end
    // all tests need about 35000 cycles
    initial begin
        repeat (90000) @(posedge i_clk);
        fails++;
        $display("watchdog expired");
        wrap_up;
    end
endmodule : tb
